// ---- hw/crf_pkg.sv ----
// Purpose: shared constants for the cpu register file and unlock block
// Assumes: 8-bit i/o bus, 5-bit working register index
// Notes: offsets are i/o addresses within the cpu register window
package crf_pkg;
  localparam int unsigned NUM_REGS = 32;
  localparam logic [4:0] UPPER_BASE = 5'h10; // first immediate-capable register
  localparam logic [4:0] PTR0_LO = 5'h1A; // pointer pair 0 low byte
  localparam logic [4:0] PTR1_LO = 5'h1C; // pointer pair 1 low byte
  localparam logic [4:0] PTR2_LO = 5'h1E; // pointer pair 2 low byte
  localparam logic [7:0] OFS_UNLOCK_KEY = 8'h04;
  localparam logic [7:0] OFS_STACK_LO = 8'h0D;
  localparam logic [7:0] OFS_STACK_HI = 8'h0E;
  localparam logic [7:0] OFS_STATUS = 8'h0F;
  localparam logic [7:0] KEY_PROT_IO = 8'hD8;
  localparam logic [7:0] KEY_SELF_PROG = 8'h9D;
  localparam int unsigned BIT_PROT_IO = 0;
  localparam int unsigned BIT_SELF_PROG = 1;
  localparam logic [2:0] UNLOCK_INSNS = 3'h4; // window length in instructions
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_STACK = 16'hFFFF; // top of data memory default
  localparam logic [1:0] PTR_FIXED = 2'h0;
  localparam logic [1:0] PTR_POSTINC = 2'h1;
  localparam logic [1:0] PTR_PREDEC = 2'h2;
  typedef enum logic [2:0] {
    CRF_IDLE = 3'b001,
    CRF_PROT_IO = 3'b010,
    CRF_SELF_PROG = 3'b100
  } crf_unlock_t;
endpackage

// ---- hw/crf_gpr_bank.sv ----
// Purpose: 32 x 8 working register file with three pointer pairs
// Assumes: byte write port plus pointer pair write port, two combinational read ports
// Notes: pointer pair write has priority over byte write on same register
`timescale 1ns/1ps
`default_nettype none
module crf_gpr_bank (
  input wire logic ref_clk_i, // cpu clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic [4:0] rd_a_idx_i, // read port a index
  input wire logic [4:0] rd_b_idx_i, // read port b index
  output logic [7:0] rd_a_data_o, // read port a data
  output logic [7:0] rd_b_data_o, // read port b data
  input wire logic wr_en_i, // byte write strobe
  input wire logic [4:0] wr_idx_i, // byte write index
  input wire logic [7:0] wr_data_i, // byte write data
  input wire logic ptr_wr_en_i, // pointer pair write strobe
  input wire logic [1:0] ptr_sel_i, // pointer pair select
  input wire logic [15:0] ptr_wr_data_i, // pointer pair write value
  output logic [15:0] ptr0_o, // pointer pair 0 value
  output logic [15:0] ptr1_o, // pointer pair 1 value
  output logic [15:0] ptr2_o // pointer pair 2 value
);
  localparam int unsigned NUM_REGS = crf_pkg::NUM_REGS;
  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] r;
  } crf_gpr_state_t;
  crf_gpr_state_t s_q, s_d;
  logic [4:0] plo;

  // pointer pair low index
  always_comb begin
    plo = crf_pkg::PTR0_LO;
    if (ptr_sel_i == 2'h1) begin
      plo = crf_pkg::PTR1_LO;
    end else if (ptr_sel_i == 2'h2) begin
      plo = crf_pkg::PTR2_LO;
    end
  end

  // next state: single-cycle byte or pair write
  always_comb begin
    s_d = s_q;
    if (wr_en_i) begin
      s_d.r[wr_idx_i] = wr_data_i; // [RULE_02]
    end
    if (ptr_wr_en_i) begin
      s_d.r[plo] = ptr_wr_data_i[7:0]; // [RULE_06]
      s_d.r[plo + 5'h01] = ptr_wr_data_i[15:8]; // [RULE_06]
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // reads and pointer views, low address is lsb
  assign rd_a_data_o = s_q.r[rd_a_idx_i]; // [RULE_02]
  assign rd_b_data_o = s_q.r[rd_b_idx_i];
  assign ptr0_o = {s_q.r[crf_pkg::PTR0_LO + 5'h01], s_q.r[crf_pkg::PTR0_LO]}; // [RULE_04]
  assign ptr1_o = {s_q.r[crf_pkg::PTR1_LO + 5'h01], s_q.r[crf_pkg::PTR1_LO]}; // [RULE_04]
  assign ptr2_o = {s_q.r[crf_pkg::PTR2_LO + 5'h01], s_q.r[crf_pkg::PTR2_LO]}; // [RULE_04]
endmodule
`default_nettype wire

// ---- hw/crf_wide_stage.sv ----
// Purpose: staging latches for 16/24-bit peripheral registers on an 8-bit bus
// Assumes: byte_sel 0 = lsb, 1 = middle (msb of a 16-bit value), 2 = msb; top marks the msb of the value
// Notes: one shared latch pair for all wide registers
`timescale 1ns/1ps
`default_nettype none
module crf_wide_stage (
  input wire logic ref_clk_i, // cpu clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic wr_i, // peripheral write strobe to a wide register
  input wire logic rd_i, // peripheral read strobe of a wide register
  input wire logic [1:0] byte_sel_i, // byte within the wide register
  input wire logic is_wide24_i, // register is 24 bits
  input wire logic [7:0] wdata_i, // bus write data
  input wire logic [23:0] live_i, // current peripheral register value
  output logic [7:0] rdata_o, // bus read data
  output logic commit_o, // pulse: write full value this cycle
  output logic [23:0] commit_data_o // value to write on commit
);
  typedef struct packed {
    logic [7:0] t0;
    logic [7:0] t1;
  } crf_stage_state_t;
  crf_stage_state_t s_q, s_d;
  logic top;

  assign top = is_wide24_i ? (byte_sel_i == 2'h2) : (byte_sel_i == 2'h1);

  // latch updates on lower-byte writes and lsb reads
  always_comb begin
    s_d = s_q;
    if (wr_i && !top) begin
      if (byte_sel_i == 2'h0) begin
        s_d.t0 = wdata_i; // [RULE_09]
      end else begin
        s_d.t1 = wdata_i; // [RULE_15]
      end
    end
    if (rd_i && byte_sel_i == 2'h0) begin
      s_d.t0 = live_i[15:8]; // [RULE_11]
      s_d.t1 = live_i[23:16]; // [RULE_15]
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // reads of upper bytes come from the latches
  always_comb begin
    rdata_o = live_i[7:0];
    if (byte_sel_i == 2'h1) begin
      rdata_o = s_q.t0; // [RULE_12]
    end else if (byte_sel_i == 2'h2) begin
      rdata_o = s_q.t1; // [RULE_15]
    end
  end

  assign commit_o = wr_i && top; // [RULE_10]
  assign commit_data_o = is_wide24_i ? {wdata_i, s_q.t1, s_q.t0}
                                     : {8'h00, wdata_i, s_q.t0}; // [RULE_10] [RULE_15]
  // [RULE_08] every wide register goes through this latch
endmodule
`default_nettype wire

// ---- hw/crf_top.sv ----
// Purpose: cpu working registers, wide-register staging and config unlock
// Assumes: core gives decoded strobes, one insn_done pulse per instruction
// Notes: own i/o registers at unlock key, stack pointer and status offsets
//
// Functional notes
// RULE_01: thirty-two 8-bit working registers, separate space
// RULE_02: register access completes in one cycle
// RULE_03: immediate instructions use registers 16 to 31
// RULE_04: registers 26 to 31 form three pointers
// RULE_05: highest pair also addresses program memory
// RULE_06: lower register holds pointer low byte
// RULE_07: pointers support displacement, increment and decrement
// RULE_08: wide registers go through byte staging latch
// RULE_09: low byte write loads latch only
// RULE_10: high byte write commits latch and byte
// RULE_11: low byte read captures high byte
// RULE_12: high byte read returns latch contents
// RULE_13: software accesses low byte before high
// RULE_14: software guards latch against interrupts
// RULE_15: 24-bit registers use two latches
// RULE_16: protected changes need prior valid key
// RULE_17: protected write within four instructions of key
// RULE_18: software sets enable bit with data
// RULE_19: io unlock ends on writes, memory access, sleep
// RULE_20: self-program unlock ends on memory access, sleep
// RULE_21: interrupts held pending while unlock active
// RULE_22: key values select protected or self-program mode
// RULE_23: key reads mode bits, upper bits zero
// RULE_24: instruction counter closes the window
`timescale 1ns/1ps
`default_nettype none
module crf_top (
  input wire logic ref_clk_i, // cpu clock, 10 MHz
  input wire logic arst_n_i, // async reset, active low
  // working register ports
  input wire logic [4:0] rs_idx_i, // source operand index
  input wire logic [4:0] rd_idx_i, // destination operand index
  output logic [7:0] rs_data_o, // source operand value
  output logic [7:0] rd_data_o, // destination operand value
  input wire logic gpr_we_i, // write result to destination
  input wire logic imm_op_i, // instruction has constant operand
  input wire logic [3:0] imm_reg_i, // 4-bit register field of immediate insn
  input wire logic [7:0] gpr_wdata_i, // result byte
  // pointer ports
  input wire logic ptr_use_i, // load/store through a pointer
  input wire logic [1:0] ptr_sel_i, // pointer pair select
  input wire logic [1:0] ptr_mode_i, // fixed, post-increment, pre-decrement
  input wire logic [5:0] ptr_disp_i, // fixed displacement
  output logic [15:0] ptr_addr_o, // effective data address
  output logic [15:0] prog_ptr_o, // program memory pointer
  // i/o bus to cpu registers
  input wire logic io_we_i, // i/o write strobe
  input wire logic io_re_i, // i/o read strobe
  input wire logic [7:0] io_addr_i, // i/o offset
  input wire logic [7:0] io_wdata_i, // i/o write data
  output logic [7:0] io_rdata_o, // i/o read data
  // wide peripheral register access
  input wire logic wide_we_i, // write to a wide peripheral byte
  input wire logic wide_re_i, // read of a wide peripheral byte
  input wire logic [1:0] wide_byte_i, // byte within wide register
  input wire logic wide24_i, // register is 24 bits
  input wire logic [23:0] wide_live_i, // live peripheral value
  output logic [7:0] wide_rdata_o, // byte returned to cpu
  output logic wide_commit_o, // commit strobe to peripheral
  output logic [23:0] wide_commit_data_o, // committed value
  // unlock related
  input wire logic insn_done_i, // pulse per executed instruction
  input wire logic data_wr_i, // any cpu write to i/o or data memory
  input wire logic nvm_acc_i, // load/store to flash, nvm ctrl or eeprom
  input wire logic sleep_i, // sleep instruction executed
  input wire logic prot_wr_i, // write request to a protected register
  input wire logic nvm_cmd_wr_i, // write request to nvm command register
  output logic prot_wr_ok_o, // protected write allowed
  output logic nvm_cmd_ok_o, // nvm command write allowed
  output logic irq_hold_o, // interrupts held pending
  output logic [7:0] status_o, // cpu status flags
  output logic [15:0] stack_o // stack pointer
);
  typedef struct packed {
    crf_pkg::crf_unlock_t mode;
    logic [2:0] cnt;
    logic [7:0] sp_tmp;
    logic [15:0] sp;
    logic [7:0] cpu_status_flags;
  } crf_top_state_t;
  crf_top_state_t s_q, s_d;

  // ----------------------------------------------------------------
  // working registers
  // ----------------------------------------------------------------
  logic [4:0] dst_idx;
  logic [15:0] ptr0, ptr1, ptr2, ptr_base, ptr_new;
  logic ptr_upd;

  // immediate forms reach only the upper half
  assign dst_idx = imm_op_i ? (crf_pkg::UPPER_BASE | {1'b0, imm_reg_i}) : rd_idx_i; // [RULE_03]

  // pointer select and address arithmetic
  always_comb begin
    ptr_base = ptr0;
    if (ptr_sel_i == 2'h1) begin
      ptr_base = ptr1;
    end else if (ptr_sel_i == 2'h2) begin
      ptr_base = ptr2;
    end
    ptr_addr_o = ptr_base + {10'h000, ptr_disp_i}; // [RULE_07]
    ptr_new = ptr_base;
    ptr_upd = 1'b0;
    if (ptr_use_i && ptr_mode_i == crf_pkg::PTR_POSTINC) begin
      ptr_new = ptr_base + 16'h0001; // [RULE_07]
      ptr_upd = 1'b1;
    end else if (ptr_use_i && ptr_mode_i == crf_pkg::PTR_PREDEC) begin
      ptr_new = ptr_base - 16'h0001; // [RULE_07]
      ptr_addr_o = ptr_new;
      ptr_upd = 1'b1;
    end
  end

  assign prog_ptr_o = ptr2; // [RULE_05]

  // thirty-two working registers outside data space
  crf_gpr_bank u_bank ( // [RULE_01]
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .rd_a_idx_i(rs_idx_i),
    .rd_b_idx_i(dst_idx),
    .rd_a_data_o(rs_data_o),
    .rd_b_data_o(rd_data_o),
    .wr_en_i(gpr_we_i),
    .wr_idx_i(dst_idx),
    .wr_data_i(gpr_wdata_i),
    .ptr_wr_en_i(ptr_upd),
    .ptr_sel_i(ptr_sel_i),
    .ptr_wr_data_i(ptr_new),
    .ptr0_o(ptr0),
    .ptr1_o(ptr1),
    .ptr2_o(ptr2)
  );

  // ----------------------------------------------------------------
  // wide register staging
  // ----------------------------------------------------------------
  // software orders low before high; latch gives coherence
  crf_wide_stage u_stage ( // [RULE_08] [RULE_13]
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .wr_i(wide_we_i),
    .rd_i(wide_re_i),
    .byte_sel_i(wide_byte_i),
    .is_wide24_i(wide24_i),
    .wdata_i(io_wdata_i),
    .live_i(wide_live_i),
    .rdata_o(wide_rdata_o),
    .commit_o(wide_commit_o),
    .commit_data_o(wide_commit_data_o)
  );

  // ----------------------------------------------------------------
  // unlock control
  // ----------------------------------------------------------------
  logic key_wr, open_io, open_spm, end_io, end_spm, win_over;
  logic io_active, spm_active;

  assign io_active = (s_q.mode == crf_pkg::CRF_PROT_IO);
  assign spm_active = (s_q.mode == crf_pkg::CRF_SELF_PROG);
  assign key_wr = io_we_i && io_addr_i == crf_pkg::OFS_UNLOCK_KEY;
  assign open_io = key_wr && io_wdata_i == crf_pkg::KEY_PROT_IO; // [RULE_22]
  assign open_spm = key_wr && io_wdata_i == crf_pkg::KEY_SELF_PROG; // [RULE_22]
  // window ends when the fourth instruction completes
  assign win_over = insn_done_i && s_q.cnt == crf_pkg::UNLOCK_INSNS - 3'h1; // [RULE_24]
  assign end_io = data_wr_i || nvm_acc_i || sleep_i; // [RULE_19]
  assign end_spm = nvm_acc_i || sleep_i; // [RULE_20]

  // grants, checked against the current open window
  assign prot_wr_ok_o = prot_wr_i && io_active; // [RULE_16] [RULE_17]
  assign nvm_cmd_ok_o = nvm_cmd_wr_i && spm_active; // [RULE_16] [RULE_20]
  assign irq_hold_o = !(s_q.mode == crf_pkg::CRF_IDLE); // [RULE_21]

  // next state for unlock and own i/o registers
  always_comb begin
    s_d = s_q;
    unique case (s_q.mode)
      crf_pkg::CRF_IDLE: begin
        s_d.cnt = 3'h0;
      end
      crf_pkg::CRF_PROT_IO: begin
        if (end_io || win_over) begin
          s_d.mode = crf_pkg::CRF_IDLE; // [RULE_19] [RULE_24]
        end
        if (insn_done_i) begin
          s_d.cnt = s_q.cnt + 3'h1; // [RULE_17]
        end
      end
      crf_pkg::CRF_SELF_PROG: begin
        if (end_spm || win_over) begin
          s_d.mode = crf_pkg::CRF_IDLE; // [RULE_20] [RULE_24]
        end
        if (insn_done_i) begin
          s_d.cnt = s_q.cnt + 3'h1; // [RULE_20]
        end
      end
      default: begin
        s_d.mode = crf_pkg::CRF_IDLE;
      end
    endcase
    // a fresh key restarts the window
    if (open_io) begin
      s_d.mode = crf_pkg::CRF_PROT_IO; // [RULE_22]
      s_d.cnt = 3'h0;
    end else if (open_spm) begin
      s_d.mode = crf_pkg::CRF_SELF_PROG; // [RULE_22]
      s_d.cnt = 3'h0;
    end
    // stack pointer: low write staged, high write commits
    if (io_we_i && io_addr_i == crf_pkg::OFS_STACK_LO) begin
      s_d.sp_tmp = io_wdata_i; // [RULE_09]
    end
    if (io_we_i && io_addr_i == crf_pkg::OFS_STACK_HI) begin
      s_d.sp = {io_wdata_i, s_q.sp_tmp}; // [RULE_10]
    end
    if (io_re_i && io_addr_i == crf_pkg::OFS_STACK_LO) begin
      s_d.sp_tmp = s_q.sp[15:8]; // [RULE_11]
    end
    if (io_we_i && io_addr_i == crf_pkg::OFS_STATUS) begin
      s_d.cpu_status_flags = io_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q.mode <= crf_pkg::CRF_IDLE;
      s_q.cnt <= 3'h0;
      s_q.sp_tmp <= crf_pkg::RST_BYTE;
      s_q.sp <= crf_pkg::RST_STACK;
      s_q.cpu_status_flags <= crf_pkg::RST_BYTE;
    end else begin
      s_q <= s_d;
    end
  end

  // i/o read mux
  always_comb begin
    io_rdata_o = 8'h00;
    unique case (io_addr_i)
      crf_pkg::OFS_UNLOCK_KEY: begin
        io_rdata_o = 8'h00; // [RULE_23]
        io_rdata_o[crf_pkg::BIT_PROT_IO] = io_active; // [RULE_23]
        io_rdata_o[crf_pkg::BIT_SELF_PROG] = spm_active; // [RULE_23]
      end
      crf_pkg::OFS_STACK_LO: io_rdata_o = s_q.sp[7:0];
      crf_pkg::OFS_STACK_HI: io_rdata_o = s_q.sp_tmp; // [RULE_12]
      crf_pkg::OFS_STATUS: io_rdata_o = s_q.cpu_status_flags;
      default: io_rdata_o = 8'h00;
    endcase
  end

  assign status_o = s_q.cpu_status_flags;
  assign stack_o = s_q.sp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence io_key_seq;
    open_io;
  endsequence

  AST_KEY_OPENS_IO: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE_22]
    io_key_seq |=> io_active)
    else $error("io key did not open protected mode");
  AST_KEY_OPENS_SPM: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE_22]
    open_spm |=> spm_active)
    else $error("self-program key did not open mode");
  AST_KEY_READ: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE_23]
    io_addr_i == crf_pkg::OFS_UNLOCK_KEY |-> io_rdata_o[7:2] == 6'h00
      && io_rdata_o[0] == io_active && io_rdata_o[1] == spm_active)
    else $error("unlock key read value wrong");
  AST_NO_GRANT_LOCKED: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE_16]
    !irq_hold_o |-> !prot_wr_ok_o && !nvm_cmd_ok_o)
    else $error("protected access granted while locked");
  AST_IO_END_ON_WRITE: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE_19]
    io_active && data_wr_i && !key_wr |=> !io_active)
    else $error("io unlock survived a write");
  AST_SPM_END_ON_SLEEP: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE_20]
    spm_active && (sleep_i || nvm_acc_i) && !key_wr |=> !spm_active)
    else $error("self-program unlock survived access");
  AST_WINDOW_FOUR: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE_24]
    s_q.cnt == 3'h3 && insn_done_i && !key_wr |=> s_q.mode == crf_pkg::CRF_IDLE)
    else $error("window outlived four instructions");
  AST_IRQ_HOLD: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE_21]
    open_io |=> irq_hold_o)
    else $error("interrupts not held in unlock");
  AST_SP_COMMIT: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE_10]
    io_we_i && io_addr_i == crf_pkg::OFS_STACK_HI |=>
      s_q.sp == {$past(io_wdata_i), $past(s_q.sp_tmp)})
    else $error("stack high write did not commit");
  AST_SP_LOW_ONLY: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE_09]
    io_we_i && io_addr_i == crf_pkg::OFS_STACK_LO |=> $stable(s_q.sp))
    else $error("stack low write changed value");
  AST_PTR_INC: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE_07]
    ptr_use_i && ptr_sel_i == 2'h0 && ptr_mode_i == crf_pkg::PTR_POSTINC && !gpr_we_i
      |=> ptr0 == $past(ptr0) + 16'h0001)
    else $error("pointer increment wrong");
  AST_IMM_UPPER: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) // [RULE_03]
    imm_op_i |-> dst_idx[4])
    else $error("immediate reached lower half");
endmodule
`default_nettype wire

// ---- tb/crf_periph_model.sv ----
// Purpose: peripheral with a counting 24-bit register behind the staging latches
// Assumes: commit strobe and value come straight from the block
// Notes: run makes the middle byte move so a torn read would show
`timescale 1ns/1ps
`default_nettype none
module crf_periph_model (
  input wire logic ref_clk_i, // cpu clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic run_i, // count the register upward
  input wire logic commit_i, // full value written this cycle
  input wire logic [23:0] commit_data_i, // value to take
  output logic [23:0] live_o // current register value
);
  // whole value is taken at once, so halves never mix
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      live_o <= 24'h00_0000;
    end else if (commit_i) begin
      live_o <= commit_data_i;
    end else if (run_i) begin
      live_o <= live_o + 24'h00_0100;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_crf_top.sv ----
// Purpose: self-checking bench for the register file, staging and unlock
// Assumes: inputs driven 1 ns after the rising edge
// Notes: no interrupts are raised, so software guarding is trivially kept
`timescale 1ns/1ps
`default_nettype none
module tb_crf_top;
  logic ref_clk_i = 0, arst_n_i = 0, gpr_we_i, imm_op_i, ptr_use_i, io_we_i, io_re_i;
  logic wide_we_i, wide_re_i, wide24_i, insn_done_i, data_wr_i, nvm_acc_i, sleep_i, run;
  logic prot_wr_i, nvm_cmd_wr_i, wide_commit_o, prot_wr_ok_o, nvm_cmd_ok_o, irq_hold_o;
  logic [4:0] rs_idx_i, rd_idx_i;
  logic [3:0] imm_reg_i;
  logic [1:0] ptr_sel_i, ptr_mode_i, wide_byte_i;
  logic [5:0] ptr_disp_i;
  logic [7:0] gpr_wdata_i, io_addr_i, io_wdata_i, rs_data_o, rd_data_o, io_rdata_o;
  logic [7:0] wide_rdata_o, status_o;
  logic [15:0] ptr_addr_o, prog_ptr_o, stack_o;
  logic [23:0] wide_live_i, wide_commit_data_o;
  int fail_count = 0, n_compared = 0;
  // design and far-side peripheral
  crf_top dut (.ref_clk_i, .arst_n_i, .rs_idx_i, .rd_idx_i, .rs_data_o, .rd_data_o, .gpr_we_i,
    .imm_op_i, .imm_reg_i, .gpr_wdata_i, .ptr_use_i, .ptr_sel_i, .ptr_mode_i, .ptr_disp_i,
    .ptr_addr_o, .prog_ptr_o, .io_we_i, .io_re_i, .io_addr_i, .io_wdata_i, .io_rdata_o,
    .wide_we_i, .wide_re_i, .wide_byte_i, .wide24_i, .wide_live_i, .wide_rdata_o,
    .wide_commit_o, .wide_commit_data_o, .insn_done_i, .data_wr_i, .nvm_acc_i, .sleep_i,
    .prot_wr_i, .nvm_cmd_wr_i, .prot_wr_ok_o, .nvm_cmd_ok_o, .irq_hold_o, .status_o, .stack_o);
  crf_periph_model periph (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .run_i(run),
    .commit_i(wide_commit_o), .commit_data_i(wide_commit_data_o), .live_o(wide_live_i));
  // 10 MHz clock
  always #50 ref_clk_i = ~ref_clk_i;
  function automatic logic [7:0] v(input int i);
    return 8'(i * 37 + 1);
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one i/o access; read data sampled 20 ns after the strobes are driven
  task automatic io(input logic we, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] r);
    io_we_i = we;
    io_re_i = ~we;
    io_addr_i = a;
    io_wdata_i = d;
    #20 r = io_rdata_o;
    @(posedge ref_clk_i);
    #1 io_we_i = 0;
    io_re_i = 0;
    // idle cycle so a following call never re-raises a strobe in this time step
    @(posedge ref_clk_i);
    #1;
  endtask
  // one wide-register byte access with commit sampled in its cycle
  task automatic wd(input logic we, input logic [1:0] b, input logic w24,
                    input logic [7:0] d, output logic [7:0] r, output logic [24:0] cd);
    wide_we_i = we;
    wide_re_i = ~we;
    wide_byte_i = b;
    wide24_i = w24;
    io_wdata_i = d;
    #20 r = wide_rdata_o;
    cd = {wide_commit_o, wide_commit_data_o};
    @(posedge ref_clk_i);
    #1 wide_we_i = 0;
    wide_re_i = 0;
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic step(input int n);
    insn_done_i = 1;
    repeat (n) @(posedge ref_clk_i);
    #1 insn_done_i = 0;
    @(posedge ref_clk_i);
    #1;
  endtask
  // watchdog
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    fail_count++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    logic [7:0] r;
    logic [24:0] cd;
    logic [15:0] b;
    logic [7:0] m;
    logic e;
    {gpr_we_i, imm_op_i, ptr_use_i, io_we_i, io_re_i, wide_we_i, wide_re_i, wide24_i} = 0;
    {insn_done_i, data_wr_i, nvm_acc_i, sleep_i, prot_wr_i, nvm_cmd_wr_i, run} = 0;
    {rs_idx_i, rd_idx_i, imm_reg_i, ptr_sel_i, ptr_mode_i, wide_byte_i, ptr_disp_i} = 0;
    {gpr_wdata_i, io_addr_i, io_wdata_i} = 0;
    repeat (4) @(posedge ref_clk_i);
    #1 arst_n_i = 1;
    io(0, 8'h04, 8'h00, r); chk(r, 24'h00_0000);
    io(0, 8'h0D, 8'h00, r); chk(r, 24'h00_00FF);
    io(0, 8'h0E, 8'h00, r); chk(r, 24'h00_00FF);
    io(0, 8'h0F, 8'h00, r); chk(r, 24'h00_0000);
    io(1, 8'h05, 8'h55, r);
    io(0, 8'h05, 8'h00, r); chk(r, 24'h00_0000);
    chk(stack_o, 24'h00_FFFF);
    done("reset");
    gpr_we_i = 1;
    for (int i = 0; i < 32; i++) begin
      rd_idx_i = 5'(i);
      gpr_wdata_i = v(i);
      @(posedge ref_clk_i);
      #1;
    end
    gpr_we_i = 0;
    for (int i = 0; i < 32; i++) begin
      rs_idx_i = 5'(i);
      rd_idx_i = 5'(i);
      #1 chk(rs_data_o, v(i));
      chk(rd_data_o, v(i));
    end
    rd_idx_i = 5'h00;
    imm_op_i = 1;
    imm_reg_i = 4'h3;
    gpr_wdata_i = 8'hE7;
    gpr_we_i = 1;
    @(posedge ref_clk_i);
    #1 {gpr_we_i, imm_op_i} = 0;
    rs_idx_i = 5'h13;
    #1 chk(rs_data_o, 24'h00_00E7);
    rs_idx_i = 5'h00;
    #1 chk(rs_data_o, v(0));
    done("gpr");
    b = {v(31), v(30)};
    chk(prog_ptr_o, b);
    {ptr_use_i, ptr_sel_i, ptr_mode_i, ptr_disp_i} = {1'b1, 2'h2, 2'h0, 6'h05};
    #1 chk(ptr_addr_o, b + 16'h0005);
    @(posedge ref_clk_i);
    #1 {ptr_sel_i, ptr_mode_i, ptr_disp_i} = {2'h0, 2'h1, 6'h00};
    b = {v(27), v(26)};
    #1 chk(ptr_addr_o, b);
    b = {v(29), v(28)};
    @(posedge ref_clk_i);
    #1 {ptr_sel_i, ptr_mode_i} = {2'h1, 2'h2};
    #1 chk(ptr_addr_o, b - 16'h0001);
    @(posedge ref_clk_i);
    #1 ptr_use_i = 0;
    rs_idx_i = 5'h1D;
    #1 chk(rs_data_o, (b - 16'h0001) >> 8);
    b = {v(27), v(26)} + 16'h0001;
    rs_idx_i = 5'h1A;
    #1 chk(rs_data_o, b[7:0]);
    done("pointer");
    io(1, 8'h0D, 8'h34, r); chk(stack_o, 24'h00_FFFF);
    io(1, 8'h0E, 8'h12, r); chk(stack_o, 24'h00_1234);
    io(0, 8'h0D, 8'h00, r); chk(r, 24'h00_0034);
    io(0, 8'h0E, 8'h00, r); chk(r, 24'h00_0012);
    io(1, 8'h0F, 8'hA5, r); chk(status_o, 24'h00_00A5);
    done("stack");
    wd(1, 2'h0, 0, 8'h11, r, cd); chk(cd[24], 24'h00_0000);
    wd(1, 2'h1, 0, 8'h22, r, cd); chk(cd, 25'h100_2211);
    run = 1;
    repeat (2) @(posedge ref_clk_i);
    #1 run = 0;
    wd(0, 2'h0, 0, 8'h00, r, cd); chk(r, 24'h00_0011);
    run = 1;
    @(posedge ref_clk_i);
    #1 run = 0;
    wd(0, 2'h1, 0, 8'h00, r, cd); chk(r, 24'h00_0024);
    wd(1, 2'h0, 1, 8'hAA, r, cd);
    wd(1, 2'h1, 1, 8'hBB, r, cd); chk(cd[24], 24'h00_0000);
    wd(1, 2'h2, 1, 8'hCC, r, cd); chk(cd, 25'h1CC_BBAA);
    for (int k = 0; k < 3; k++) begin
      wd(0, 2'(k), 1, 8'h00, r, cd); chk(r, 8'hAA + 8'(k * 17));
    end
    done("wide");
    prot_wr_i = 1; // enable bit rides in the same write as the data
    nvm_cmd_wr_i = 1;
    io(1, 8'h04, 8'h55, r);
    #1 chk(prot_wr_ok_o, 0);
    io(1, 8'h04, 8'hD8, r);
    #1 chk({irq_hold_o, prot_wr_ok_o, nvm_cmd_ok_o}, 3'b110);
    io(0, 8'h04, 8'h00, r); chk(r, 24'h00_0001);
    step(3);
    chk(prot_wr_ok_o, 1);
    step(1);
    chk({irq_hold_o, prot_wr_ok_o}, 2'b00);
    io(1, 8'h04, 8'h9D, r);
    io(0, 8'h04, 8'h00, r); chk(r, 24'h00_0002);
    chk({prot_wr_ok_o, nvm_cmd_ok_o}, 2'b01);
    for (int k = 0; k < 6; k++) begin
      m = (k < 3) ? 8'hD8 : 8'h9D;
      e = (k < 3) || (k != 3);
      io(1, 8'h04, m, r);
      {sleep_i, nvm_acc_i, data_wr_i} = 3'b001 << (k % 3);
      @(posedge ref_clk_i);
      #1 {sleep_i, nvm_acc_i, data_wr_i} = 0;
      chk((k < 3) ? prot_wr_ok_o : nvm_cmd_ok_o, !e);
      chk(irq_hold_o, !e);
      step(4);
    end
    done("unlock");
    tally_and_finish();
  end
endmodule
`default_nettype wire
